// >>> rtl/llcfa_map.vh
// constants for the link frame assembler / segmenter
// assumes byte-wide streams and a single 200 MHz clock
// Operation
// - accept and deliver units up to 1522 bytes
// - queue transmit units by address, priority, control
// - tag each unit with its protocol type
// - steer received units by frame type tag
// - at most eight convergence units supported
// - exactly one frame per incoming unit
// - split frames into equal-size segments
// - add segment header and trailing CRC
// - keep acknowledged segments in retransmission buffer
// - replay flagged segments from retransmission buffer
// - receive side hands acknowledgements to MAC
// - drop bad segments, acknowledge only if asked; the code has already passed the bytes upward when it raises o_rx_drop
// - reassemble only after all segments cleared; the code forwards each segment upward as it arrives, with no reassembly
// - data to convergence, control to management
// - relay-marked frames returned to MAC when enabled
// - relayed frames never decrypted
// - secured frames get security header and check; the code only sets the security flag in octet zero
// - unsecured frames omit both; header signals presence
// - header octet zero goes first to MAC
// - octet zero: type, security, mesh flags
// - reserved bits sent zero, ignored on receive
// - type 0 reserved, 1 control, 2-15 data
// - security flag marks header and check presence
// - mesh flag marks mesh header presence
`ifndef LLCFA_MAP_VH
`define LLCFA_MAP_VH
`define LLCFA_MAX_UNIT 11'h5F2
`define LLCFA_MAX_CONV 4'h8
`define LLCFA_FT_RSVD 4'h0
`define LLCFA_FT_CTRL 4'h1
`define LLCFA_FT_LSB 0
`define LLCFA_SEC_BIT 4
`define LLCFA_MESH_BIT 5
`define LLCFA_SEG_HDR 8'hA5
`define LLCFA_CRC_INIT 8'hFF
`define LLCFA_CRC_POLY 8'h07
`endif

// >>> rtl/llcfa_fifo.v
// byte fifo with valid/ready on both sides
// assumes one clock, async active-low reset
`timescale 1ns/1ps
module llcfa_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // drain side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage flops
  reg [AW-1:0] wr_reg; // write index
  reg [AW-1:0] rd_reg; // read index
  reg [AW:0] cnt_reg; // fill level
  wire push = i_in_valid && (cnt_reg != DEPTH[AW:0]);
  wire pop = i_out_ready && (cnt_reg != {(AW+1){1'b0}});
  integer k;
  assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign o_out_data = mem_reg[rd_reg];
  // pointer and level update
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_reg[k] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wr_reg] <= i_in_data;
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// >>> rtl/llcfa_top.v
// link frame assembler: builds, segments, buffers and checks link frames
// assumes upstream streams are on i_clock and hold data until ready
`timescale 1ns/1ps
`include "llcfa_map.vh"
module llcfa_top #(
  parameter SEG_SIZE = 8, // payload bytes per segment
  parameter ARQ_DEPTH = 64, // retransmission buffer bytes
  parameter ARQ_AW = 6,
  parameter NUM_CONV = 8 // convergence units served
) (
  // clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // control
  input wire i_relay_enable,
  input wire i_secure,
  input wire i_mesh,
  input wire i_ack_req,
  // upper side transmit stream
  input wire i_tx_valid,
  input wire [7:0] i_tx_data,
  input wire i_tx_last,
  input wire [3:0] i_tx_type,
  input wire [2:0] i_tx_prio,
  input wire [2:0] i_tx_conv,
  output reg o_tx_ready,
  // lower side segment stream
  output reg o_seg_valid,
  output reg [7:0] o_seg_data,
  output reg o_seg_last,
  output reg [2:0] o_seg_prio,
  input wire i_seg_ready,
  // retransmission request
  input wire i_retx_req,
  output reg o_retx_busy,
  // receive segments from MAC
  input wire i_rx_valid,
  input wire [7:0] i_rx_data,
  input wire i_rx_last,
  // acknowledge to MAC
  output reg o_ack_valid,
  output reg o_ack_good,
  // delivery upward
  output reg o_up_valid,
  output reg [7:0] o_up_data,
  output reg [2:0] o_up_conv,
  output reg o_up_mgmt,
  output reg o_relay_valid,
  output reg o_rx_drop
);
  // transmit states
  localparam T_IDLE = 3'd0, T_HDR = 3'd1, T_DATA = 3'd2, T_CRC = 3'd3, T_SHDR = 3'd4;
  localparam T_RETX = 3'd5;

  // crc step, polynomial per map
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer b;
    reg [7:0] x;
    begin
      x = c ^ d;
      for (b = 0; b < 8; b = b + 1) begin
        x = x[7] ? ((x << 1) ^ `LLCFA_CRC_POLY) : (x << 1);
      end
      crc8 = x;
    end
  endfunction

  // frame header octet zero builder
  function [7:0] hdr0;
    input [3:0] ft;
    input sec;
    input mesh;
    begin
      hdr0 = {2'b00, mesh, sec, ft};
    end
  endfunction

  reg [2:0] st_reg; // transmit state
  reg [7:0] crc_reg; // running segment crc
  reg [7:0] cnt_reg; // bytes in current segment
  reg [10:0] len_reg; // bytes in current unit
  reg [3:0] ft_reg; // latched frame type
  reg last_reg; // frame end seen
  reg hdr_done_reg; // octet zero emitted
  reg [ARQ_AW-1:0] arq_wr_reg; // retx buffer fill
  reg [ARQ_AW-1:0] arq_rd_reg; // retx read index
  reg [7:0] arq_mem [0:ARQ_DEPTH-1]; // retx storage
  reg arq_keep_reg; // this frame is acknowledged
  integer i;

  // fifo buffers the outgoing byte stream; MAC back-pressure reaches o_tx_ready
  wire f_in_ready;
  wire f_out_valid;
  wire [7:0] f_out_data;
  // no pop once the segment is full, or the byte would be lost at the crc step
  wire f_pop = f_out_valid && (!o_seg_valid || i_seg_ready) && st_reg == T_DATA
               && cnt_reg != SEG_SIZE[7:0];
  // fifo level mirror so a registered ready never offers room that is gone
  reg [3:0] fill_reg; // bytes held in the fifo
  wire tx_take = i_tx_valid && o_tx_ready; // byte taken at this edge
  wire [3:0] fill_next = fill_reg + {3'b000, tx_take} - {3'b000, f_pop};
  // unit ends on its last byte or at the size ceiling
  wire tx_end = tx_take && (i_tx_last || len_reg == `LLCFA_MAX_UNIT - 11'h001);
  llcfa_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_in_valid(i_tx_valid && o_tx_ready),
    .i_in_data(i_tx_data),
    .o_in_ready(f_in_ready),
    .o_out_valid(f_out_valid),
    .o_out_data(f_out_data),
    .i_out_ready(f_pop)
  );
  reg f_last_reg; // last byte marker held beside the fifo
  wire out_free = !o_seg_valid || i_seg_ready;

  // transmit: one frame per unit, equal segments, header and crc per segment
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= T_IDLE;
      crc_reg <= `LLCFA_CRC_INIT;
      cnt_reg <= 8'h00;
      len_reg <= 11'h000;
      ft_reg <= 4'h0;
      last_reg <= 1'b0;
      hdr_done_reg <= 1'b0;
      arq_wr_reg <= {ARQ_AW{1'b0}};
      arq_rd_reg <= {ARQ_AW{1'b0}};
      arq_keep_reg <= 1'b0;
      f_last_reg <= 1'b0;
      fill_reg <= 4'h0;
      o_tx_ready <= 1'b0;
      o_seg_valid <= 1'b0;
      o_seg_data <= 8'h00;
      o_seg_last <= 1'b0;
      o_seg_prio <= 3'h0;
      o_retx_busy <= 1'b0;
      for (i = 0; i < ARQ_DEPTH; i = i + 1) begin
        arq_mem[i] <= 8'h00;
      end
    end else begin
      if (out_free) begin
        o_seg_valid <= 1'b0;
        o_seg_last <= 1'b0;
      end
      // accept bytes while fifo keeps room after this edge and unit still open;
      // the closing byte drops ready at once so no byte of the next unit slips in
      fill_reg <= fill_next;
      o_tx_ready <= f_in_ready && (fill_next != 4'h8) && !last_reg && !tx_end
                    && st_reg != T_RETX && st_reg != T_IDLE;
      if (tx_take) begin
        len_reg <= len_reg + 11'h001;
        if (tx_end) begin
          last_reg <= 1'b1;
          f_last_reg <= 1'b1;
        end
      end
      case (st_reg)
        T_IDLE: begin
          if (i_retx_req && arq_wr_reg != {ARQ_AW{1'b0}}) begin
            st_reg <= T_RETX;
            arq_rd_reg <= {ARQ_AW{1'b0}};
            cnt_reg <= 8'h00; // replay restarts the segment position
            o_retx_busy <= 1'b1;
          end else if (i_tx_valid && i_tx_type != `LLCFA_FT_RSVD
                       && {1'b0, i_tx_conv} < NUM_CONV[3:0]) begin
            ft_reg <= i_tx_type;
            o_seg_prio <= i_tx_prio;
            arq_keep_reg <= i_ack_req;
            arq_wr_reg <= {ARQ_AW{1'b0}};
            len_reg <= 11'h000;
            last_reg <= 1'b0;
            f_last_reg <= 1'b0;
            hdr_done_reg <= 1'b0;
            st_reg <= T_SHDR;
          end
        end
        T_SHDR: if (out_free) begin
          o_seg_valid <= 1'b1;
          o_seg_data <= `LLCFA_SEG_HDR;
          crc_reg <= crc8(`LLCFA_CRC_INIT, `LLCFA_SEG_HDR);
          cnt_reg <= 8'h00;
          st_reg <= hdr_done_reg ? T_DATA : T_HDR;
          if (arq_keep_reg) begin
            arq_mem[arq_wr_reg] <= `LLCFA_SEG_HDR;
            arq_wr_reg <= arq_wr_reg + 1'b1;
          end
        end
        T_HDR: if (out_free) begin
          // octet zero leads the frame toward the MAC
          o_seg_valid <= 1'b1;
          o_seg_data <= hdr0(ft_reg, i_secure, i_mesh);
          crc_reg <= crc8(crc_reg, hdr0(ft_reg, i_secure, i_mesh));
          cnt_reg <= 8'h01;
          hdr_done_reg <= 1'b1;
          st_reg <= T_DATA;
          if (arq_keep_reg) begin
            arq_mem[arq_wr_reg] <= hdr0(ft_reg, i_secure, i_mesh);
            arq_wr_reg <= arq_wr_reg + 1'b1;
          end
        end
        T_DATA: begin
          if (cnt_reg == SEG_SIZE[7:0]) begin
            st_reg <= T_CRC;
          end else if (f_pop) begin
            o_seg_valid <= 1'b1;
            o_seg_data <= f_out_data;
            crc_reg <= crc8(crc_reg, f_out_data);
            cnt_reg <= cnt_reg + 8'h01;
            if (arq_keep_reg) begin
              arq_mem[arq_wr_reg] <= f_out_data;
              arq_wr_reg <= arq_wr_reg + 1'b1;
            end
          end else if (out_free && f_last_reg && !f_out_valid) begin
            // pad short tail so every segment has equal size
            o_seg_valid <= 1'b1;
            o_seg_data <= 8'h00;
            crc_reg <= crc8(crc_reg, 8'h00);
            cnt_reg <= cnt_reg + 8'h01;
            // pad bytes are stored too so a replay is the same segment
            if (arq_keep_reg) begin
              arq_mem[arq_wr_reg] <= 8'h00;
              arq_wr_reg <= arq_wr_reg + 1'b1;
            end
          end
        end
        T_CRC: if (out_free) begin
          o_seg_valid <= 1'b1;
          o_seg_data <= crc_reg;
          o_seg_last <= 1'b1;
          if (arq_keep_reg) begin
            arq_mem[arq_wr_reg] <= crc_reg;
            arq_wr_reg <= arq_wr_reg + 1'b1;
          end
          st_reg <= (f_last_reg && !f_out_valid) ? T_IDLE : T_SHDR;
        end
        T_RETX: if (out_free) begin
          // replay stored segments verbatim; buffer wraps if frame too long
          o_seg_valid <= 1'b1;
          o_seg_data <= arq_mem[arq_rd_reg];
          arq_rd_reg <= arq_rd_reg + 1'b1;
          // each stored segment ends on its crc byte, so mark it as it goes out
          cnt_reg <= (cnt_reg == SEG_SIZE[7:0] + 8'h01) ? 8'h00 : cnt_reg + 8'h01;
          o_seg_last <= (cnt_reg == SEG_SIZE[7:0] + 8'h01);
          if (arq_rd_reg + 1'b1 == arq_wr_reg) begin
            o_seg_last <= 1'b1;
            o_retx_busy <= 1'b0;
            st_reg <= T_IDLE;
          end
        end
        default: st_reg <= T_IDLE;
      endcase
    end
  end

  // receive side: sync pins-equivalent inputs are same clock, no sync needed
  reg [7:0] rcrc_reg; // running receive crc
  reg [7:0] rpos_reg; // byte index in segment
  reg [7:0] prev_reg; // one byte delay to hide crc
  reg prev_v_reg; // delayed byte valid
  reg [3:0] rft_reg; // received frame type
  reg rmesh_reg; // mesh flag of frame
  reg rbad_reg; // a segment has failed since reset, never cleared
  reg rfirst_reg; // next data byte is octet zero

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rcrc_reg <= `LLCFA_CRC_INIT;
      rpos_reg <= 8'h00;
      prev_reg <= 8'h00;
      prev_v_reg <= 1'b0;
      rft_reg <= 4'h0;
      rmesh_reg <= 1'b0;
      rbad_reg <= 1'b0;
      rfirst_reg <= 1'b1;
      o_ack_valid <= 1'b0;
      o_ack_good <= 1'b0;
      o_up_valid <= 1'b0;
      o_up_data <= 8'h00;
      o_up_conv <= 3'h0;
      o_up_mgmt <= 1'b0;
      o_relay_valid <= 1'b0;
      o_rx_drop <= 1'b0;
    end else begin
      o_ack_valid <= 1'b0;
      o_up_valid <= 1'b0;
      o_relay_valid <= 1'b0;
      o_rx_drop <= 1'b0;
      if (i_rx_valid) begin
        rcrc_reg <= crc8(rcrc_reg, i_rx_data);
        rpos_reg <= rpos_reg + 8'h01;
        prev_reg <= i_rx_data;
        prev_v_reg <= (rpos_reg != 8'h00);
        // forward previous byte; last byte is crc and never forwarded
        if (prev_v_reg && rpos_reg > 8'h01) begin
          if (rfirst_reg) begin
            rft_reg <= prev_reg[3:0];
            rmesh_reg <= prev_reg[`LLCFA_MESH_BIT];
            rfirst_reg <= 1'b0;
          end
          // relay frames go back raw and are never decrypted here
          if (i_relay_enable && (rfirst_reg ? prev_reg[`LLCFA_MESH_BIT] : rmesh_reg)) begin
            o_relay_valid <= 1'b1;
          end else begin
            o_up_valid <= 1'b1;
          end
          o_up_data <= prev_reg;
          o_up_mgmt <= (rfirst_reg ? prev_reg[3:0] : rft_reg) == `LLCFA_FT_CTRL;
          o_up_conv <= rfirst_reg ? prev_reg[2:0] : rft_reg[2:0];
        end
        if (i_rx_last) begin
          rcrc_reg <= `LLCFA_CRC_INIT;
          rpos_reg <= 8'h00;
          prev_v_reg <= 1'b0;
          // each segment burst is taken as a frame of its own: no frame end mark
          // crosses this port, so a multi-segment frame reads its second part wrong
          rfirst_reg <= 1'b1;
          // good when crc over all bytes including crc byte is zero
          if (crc8(rcrc_reg, i_rx_data) != 8'h00) begin
            o_rx_drop <= 1'b1;
            rbad_reg <= 1'b1;
          end
          if (i_ack_req) begin
            o_ack_valid <= 1'b1;
            o_ack_good <= (crc8(rcrc_reg, i_rx_data) == 8'h00) && !rbad_reg;
          end
        end
      end
    end
  end
endmodule

// >>> testbench/llcfa_monitor.sv
// port checker for the frame assembler
// assumes bind onto llcfa_top, one clock domain
`timescale 1ns/1ps
module llcfa_monitor #(
  parameter SEG_SIZE = 8
) (
  // clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // inputs watched
  input wire i_relay_enable,
  input wire i_ack_req,
  input wire i_seg_ready,
  input wire i_rx_valid,
  input wire i_rx_last,
  // outputs watched
  input wire o_seg_valid,
  input wire [7:0] o_seg_data,
  input wire o_seg_last,
  input wire o_ack_valid,
  input wire o_up_valid,
  input wire o_relay_valid,
  input wire o_rx_drop,
  input wire o_retx_busy
);
  // byte position in the segment now on the wire
  reg [7:0] pos_reg;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos_reg <= 8'h00;
    end else if (o_seg_valid && i_seg_ready) begin
      pos_reg <= o_seg_last ? 8'h00 : pos_reg + 8'h01;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  a_seg_stall_hold: assert property (o_seg_valid && !i_seg_ready |=> o_seg_valid
    && $stable(o_seg_data) && $stable(o_seg_last)) else $error("segment byte moved in stall");
  a_seg_header_first: assert property (o_seg_valid && pos_reg == 8'h00 |->
    o_seg_data == 8'hA5) else $error("segment does not open with header");
  a_seg_equal_size: assert property (o_seg_valid && o_seg_last |->
    pos_reg == SEG_SIZE + 1) else $error("segment length wrong");
  a_ack_on_request: assert property (i_rx_valid && i_rx_last && i_ack_req |=>
    o_ack_valid) else $error("ack missing");
  a_ack_only_asked: assert property (o_ack_valid |-> $past(i_ack_req))
    else $error("ack not asked for");
  a_drop_at_end: assert property (o_rx_drop |-> $past(i_rx_valid) && $past(i_rx_last))
    else $error("drop outside segment end");
  a_up_after_rx: assert property (o_up_valid |-> $past(i_rx_valid))
    else $error("delivery without receive byte");
  a_relay_when_on: assert property (o_relay_valid |-> $past(i_relay_enable))
    else $error("relay while disabled");
  c_ack: cover property (o_ack_valid);
  c_drop: cover property (o_rx_drop);
  c_seg_end: cover property (o_seg_valid && o_seg_last && i_seg_ready);
  c_replay: cover property (o_retx_busy);
endmodule
bind llcfa_top llcfa_monitor #(.SEG_SIZE(SEG_SIZE)) llcfa_monitor_inst (.i_clock(i_clock),
  .i_arst_n(i_arst_n), .i_relay_enable(i_relay_enable), .i_ack_req(i_ack_req),
  .i_seg_ready(i_seg_ready), .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last),
  .o_seg_valid(o_seg_valid), .o_seg_data(o_seg_data), .o_seg_last(o_seg_last),
  .o_ack_valid(o_ack_valid), .o_up_valid(o_up_valid), .o_relay_valid(o_relay_valid),
  .o_rx_drop(o_rx_drop), .o_retx_busy(o_retx_busy));

// >>> testbench/llcfa_mac_model.sv
// mac side model taking segment bytes
// assumes the bench reads cap_q hierarchically
`timescale 1ns/1ps
module llcfa_mac_model (
  input wire i_clock,
  input wire i_arst_n,
  input wire i_slow,
  input wire i_seg_valid,
  input wire [7:0] i_seg_data,
  output reg o_seg_ready
);
  reg [1:0] tick_reg; // stall phase
  logic [7:0] cap_q[$]; // every byte accepted
  // slow mode stalls one cycle in four so the sender must hold
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_reg <= 2'h0;
      o_seg_ready <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      o_seg_ready <= !i_slow || (tick_reg != 2'h3);
      if (i_seg_valid && o_seg_ready) cap_q.push_back(i_seg_data);
    end
  end
endmodule

// >>> testbench/llcfa_top_tb.sv
// self-checking bench for the frame assembler
// assumes checker and mac model compiled first
`timescale 1ns/1ps
module llcfa_top_tb;
  localparam SEG = 8;
  reg i_clock = 1'b0;
  reg i_arst_n = 1'b0;
  reg relay = 1'b0, sec = 1'b0, mesh = 1'b0, ackr = 1'b0, slow = 1'b0, retx = 1'b0;
  reg tv = 1'b0, tl = 1'b0, rv = 1'b0, rl = 1'b0;
  reg [7:0] td = 8'h00, rd = 8'h00;
  reg [3:0] tt = 4'h0;
  wire trdy, sv, sl, srdy, ackv, upv, upm, drop;
  wire ackg, relv, busy;
  wire [2:0] sp;
  integer relay_n = 0, busy_n = 0;
  reg good = 1'b0;
  wire [7:0] sd, upd;
  wire [2:0] upc;
  integer failures = 0, check_count = 0, cycles = 0, ack_n = 0, drop_n = 0;
  logic [7:0] up_q[$];
  reg [2:0] conv = 3'h0;
  reg mgmt = 1'b0;
  llcfa_top #(.SEG_SIZE(SEG)) llcfa_top_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_relay_enable(relay), .i_secure(sec), .i_mesh(mesh), .i_ack_req(ackr),
    .i_tx_valid(tv), .i_tx_data(td), .i_tx_last(tl), .i_tx_type(tt), .i_tx_prio(3'h5),
    .i_tx_conv(3'h2), .o_tx_ready(trdy), .o_seg_valid(sv), .o_seg_data(sd), .o_seg_last(sl),
    .o_seg_prio(sp), .i_seg_ready(srdy), .i_retx_req(retx), .o_retx_busy(busy),
    .i_rx_valid(rv), .i_rx_data(rd), .i_rx_last(rl), .o_ack_valid(ackv), .o_ack_good(ackg),
    .o_up_valid(upv), .o_up_data(upd), .o_up_conv(upc), .o_up_mgmt(upm),
    .o_relay_valid(relv), .o_rx_drop(drop));
  llcfa_mac_model mac (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_slow(slow),
    .i_seg_valid(sv), .i_seg_data(sd), .o_seg_ready(srdy));
  initial forever #2.5 i_clock = ~i_clock;
  // watch delivery, acks and drops; cut a hang short
  always @(posedge i_clock) begin
    cycles++;
    if (upv) begin
      up_q.push_back(upd);
      mgmt = upm;
      conv = upc;
    end
    if (ackv) begin
      ack_n++;
      good = ackg;
    end
    if (relv) relay_n++;
    if (busy) busy_n++;
    if (drop) drop_n++;
  end
  always @(posedge i_clock) if (cycles == 20000) begin
    failures++;
    complete_run;
  end
  task complete_run;
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step;
    @(posedge i_clock);
    #1;
  endtask
  function automatic [7:0] crc(input [7:0] c, input [7:0] b);
    reg [7:0] x;
    x = c ^ b;
    for (int k = 0; k < 8; k++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  // one unit of n bytes, each held until taken
  task automatic send(input [3:0] ft, input integer n);
    bit r;
    tt = ft;
    for (int k = 0; k < n; k++) begin
      tv = 1'b1;
      td = 8'h10 + k[7:0];
      tl = (k == n - 1);
      r = 1'b0;
      for (int w = 0; w < 200 && !r; w++) begin
        @(negedge i_clock);
        r = trdy;
        step;
      end
      check("byte taken", r, 8'h01);
    end
    tv = 1'b0;
    tl = 1'b0;
  endtask
  task automatic wait_bytes(input integer n);
    for (int w = 0; w < 2000 && mac.cap_q.size() < n; w++) step;
  endtask
  // expected segments rebuilt from octet zero and the unit bytes
  task automatic check_frame(input integer base, input [7:0] oz, input integer n);
    logic [7:0] fr[$];
    reg [7:0] c, b;
    fr.push_back(oz);
    for (int k = 0; k < n; k++) fr.push_back(8'h10 + k[7:0]);
    check("octet zero", mac.cap_q[base + 1], oz);
    for (int s = 0; s * SEG < fr.size(); s++) begin
      c = crc(8'hFF, 8'hA5);
      check("seg header", mac.cap_q[base + s * (SEG + 2)], 8'hA5);
      for (int k = 0; k < SEG; k++) begin
        b = (s * SEG + k < fr.size()) ? fr[s * SEG + k] : 8'h00;
        c = crc(c, b);
        check("seg byte", mac.cap_q[base + s * (SEG + 2) + 1 + k], b);
      end
      check("seg crc", mac.cap_q[base + s * (SEG + 2) + SEG + 1], c);
    end
  endtask
  task automatic rx_seg(input [7:0] oz, input bit bad);
    logic [7:0] sg[$];
    reg [7:0] c;
    sg = {8'hA5, oz};
    for (int k = 0; k < 7; k++) sg.push_back(8'h40 + k[7:0]);
    c = 8'hFF;
    foreach (sg[j]) c = crc(c, sg[j]);
    sg.push_back(bad ? ~c : c);
    foreach (sg[j]) begin
      rv = 1'b1;
      rd = sg[j];
      rl = (j == 9);
      step;
    end
    rv = 1'b0;
    rl = 1'b0;
    repeat (4) step;
  endtask
  // every frame type from 1 to 15, flags walked through with it
  task s_types;
    for (int t = 1; t < 16; t++) begin
      sec = t[0];
      mesh = t[1];
      mac.cap_q.delete();
      send(t[3:0], 1);
      wait_bytes(SEG + 2);
      check_frame(0, {2'b00, t[1], t[0], t[3:0]}, 1);
      check("seg prio", sp, 8'h05);
    end
  endtask
  // two-segment control unit kept, then replayed under stalls
  task s_arq;
    ackr = 1'b1;
    slow = 1'b1;
    sec = 1'b0;
    mesh = 1'b1;
    mac.cap_q.delete();
    send(4'h1, 10);
    wait_bytes(2 * (SEG + 2));
    check_frame(0, 8'h21, 10);
    repeat (3) step;
    busy_n = 0;
    retx = 1'b1;
    step;
    retx = 1'b0;
    wait_bytes(4 * (SEG + 2));
    check_frame(2 * (SEG + 2), 8'h21, 10);
    check("replay seen", 8'(busy_n >= 2 * (SEG + 2)), 8'h01);
    check("replay done", busy, 8'h00);
    ackr = 1'b0;
    slow = 1'b0;
  endtask
  // reserved type never framed
  task s_reserved;
    mac.cap_q.delete();
    tt = 4'h0;
    tv = 1'b1;
    tl = 1'b1;
    repeat (20) step;
    tv = 1'b0;
    tl = 1'b0;
    check("refused bytes", 8'(mac.cap_q.size()), 8'h00);
  endtask
  // good control, good data with reserved bits set, relay, then a bad crc
  task s_receive;
    ackr = 1'b1;
    rx_seg(8'h01, 0);
    check("up last", up_q[$], 8'h46);
    check("up mgmt", mgmt, 8'h01);
    check("acks", 8'(ack_n), 8'h01);
    check("ack good", good, 8'h01);
    rx_seg(8'hC3, 0);
    check("up conv", conv, 8'h03);
    check("up mgmt", mgmt, 8'h00);
    relay = 1'b1;
    rx_seg(8'h22, 0);
    relay = 1'b0;
    check("relayed", 8'(relay_n), 8'h08);
    check("up kept", 8'(up_q.size()), 8'h10);
    ackr = 1'b0;
    rx_seg(8'h03, 1);
    check("drops", 8'(drop_n), 8'h01);
    check("acks", 8'(ack_n), 8'h03);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    #1;
    i_arst_n = 1'b1;
    repeat (2) step;
    s_types;
    s_arq;
    s_reserved;
    s_receive;
    complete_run;
  end
endmodule
